/* File: logic/etc_top.sv */
// edge and current control registers with apb slave
//
// Summary of operation
// - source code 11 pin one, 10 pin two, 01 compare, 00 timer.
// - edge-2 seen bit sets on a qualifying edge-2 event.
// - edge-1 seen bit, bit 0, sets on a qualifying edge-1 event.
// - trim bits 15:10, range 9:8, low byte zero, reset zero.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module etc_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // edge sources
  input wire logic EDGE_PIN_ONE_I,
  input wire logic EDGE_PIN_TWO_I,
  input wire logic OUTPUT_COMPARE_ONE_I,
  input wire logic GENERAL_TIMER_I,
  // analog controls
  output logic [5:0] CURRENT_TRIM_O,
  output logic [1:0] CURRENT_RANGE_O,
  output logic DELAY_GEN_ENABLE_O,
  // interrupt
  output logic IRQ_O
);
  logic [15:0] edge_ctl;
  logic [15:0] cur_ctl;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  wire logic hit1;
  wire logic hit2;
  wire etc_pkg::etc_src_t srcs;
  // bus decode
  wire logic acc = PSEL_I & PENABLE_I;
  wire logic wr = acc & PWRITE_I;
  wire logic hit_edge = PADDR_I == etc_pkg::ADDR_EDGE_CTL;
  wire logic hit_cur = PADDR_I == etc_pkg::ADDR_CUR_CTL;
  wire logic hit_stat = PADDR_I == etc_pkg::ADDR_IRQ_STAT;
  wire logic hit_mask = PADDR_I == etc_pkg::ADDR_IRQ_MASK;
  wire logic mapped = hit_edge | hit_cur | hit_stat | hit_mask;
  wire logic [15:0] wd = PWDATA_I[15:0];
  // seen bits written by software, hardware set wins
  wire logic [1:0] ctl_seen = {wd[etc_pkg::POS_SEEN2],
                               wd[etc_pkg::POS_SEEN1]};
  wire logic [1:0] seen_now = {edge_ctl[etc_pkg::POS_SEEN2],
                               edge_ctl[etc_pkg::POS_SEEN1]};
  wire logic [1:0] hits = {hit2, hit1};
  wire logic [1:0] next_seen = ((wr & hit_edge) ? ctl_seen : seen_now)
                               | hits;
  // next control values, only writable bits taken from the bus
  wire logic [15:0] next_edge = (wr & hit_edge)
    ? ((wd & etc_pkg::EDGE_WMASK) | {14'h0000, next_seen})
    : ((edge_ctl & ~16'h0003) | {14'h0000, next_seen});
  wire logic [15:0] next_cur = (wr & hit_cur)
    ? (wd & etc_pkg::CUR_WMASK) : cur_ctl;
  // interrupt status, write one to clear, an edge wins
  wire logic [1:0] next_stat = ((wr & hit_stat) ? (irq_stat & ~wd[1:0])
                                : irq_stat) | hits;
  wire logic [1:0] next_mask = (wr & hit_mask) ? wd[1:0] : irq_mask;
  // read data select, holes read zero
  wire logic [15:0] rd_mux = hit_edge ? edge_ctl :
                             hit_cur ? cur_ctl :
                             hit_stat ? {14'h0000, irq_stat} :
                             hit_mask ? {14'h0000, irq_mask} : 16'h0000;
  // source bundle shared by both edge channels
  assign srcs = '{pin_one: EDGE_PIN_ONE_I, pin_two: EDGE_PIN_TWO_I,
                  compare: OUTPUT_COMPARE_ONE_I, timer: GENERAL_TIMER_I};
  // edge channels
  etc_edge_det u_edge1 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .src_i(srcs),
    .sel_i(edge_ctl[etc_pkg::POS_SRC1 +: 2]),
    .falling_i(edge_ctl[etc_pkg::POS_POL1]),
    .hit_o(hit1)
  );
  etc_edge_det u_edge2 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .src_i(srcs),
    .sel_i(edge_ctl[etc_pkg::POS_SRC2 +: 2]),
    .falling_i(edge_ctl[etc_pkg::POS_POL2]),
    .hit_o(hit2)
  );
  // register state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      edge_ctl <= etc_pkg::EDGE_RESET;
      cur_ctl <= etc_pkg::CUR_RESET;
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      edge_ctl <= next_edge;
      cur_ctl <= next_cur;
      irq_stat <= next_stat;
      irq_mask <= next_mask;
    end
  end
  // registered outputs
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      CURRENT_TRIM_O <= 6'h00;
      CURRENT_RANGE_O <= 2'h0;
      DELAY_GEN_ENABLE_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped;
      PRDATA_O <= {16'h0000, rd_mux};
      CURRENT_TRIM_O <= next_cur[etc_pkg::POS_TRIM +: 6];
      CURRENT_RANGE_O <= next_cur[etc_pkg::POS_RANGE +: 2];
      DELAY_GEN_ENABLE_O <= next_edge[etc_pkg::POS_DELAY_GEN];
      IRQ_O <= |(next_stat & next_mask);
    end
  end
  // seen bit follows a qualifying edge
  seen_one_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hit1 |=> edge_ctl[etc_pkg::POS_SEEN1])
    else $error("edge one seen bit not set");
  seen_two_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hit2 |=> edge_ctl[etc_pkg::POS_SEEN2])
    else $error("edge two seen bit not set");
  cur_low_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cur_ctl[7:0] == 8'h00)
    else $error("current low byte not zero");
  trim_out_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr && hit_cur) |=> CURRENT_TRIM_O == $past(PWDATA_I[15:10]))
    else $error("trim output wrong");
  sel_pin_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (edge_ctl[3:2] == etc_pkg::SRC_PIN_ONE && !edge_ctl[4]
     && EDGE_PIN_ONE_I && !$past(EDGE_PIN_ONE_I)
     && $stable(edge_ctl[4:2])) |-> hit1)
    else $error("pin one edge not seen");
  fall_pol_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (edge_ctl[6:5] == etc_pkg::SRC_TIMER && edge_ctl[7]
     && !GENERAL_TIMER_I && $past(GENERAL_TIMER_I)
     && $stable(edge_ctl[7:5])) |-> hit2)
    else $error("falling edge not seen");
  irq_lvl_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    IRQ_O == |(irq_stat & irq_mask))
    else $error("irq level mismatch");
  ready_next_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && !PENABLE_I) |=> PREADY_O)
    else $error("ready late");
  ready_once_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PREADY_O |=> !PREADY_O)
    else $error("ready held too long");

  // holes answer with an error and zero data
  err_unmap_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && !PENABLE_I && !mapped)
    |=> (PSLVERR_O && PRDATA_O == 32'h0000_0000))
    else $error("unmapped access not flagged");
  err_mapped_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && !PENABLE_I && mapped) |=> !PSLVERR_O)
    else $error("error on a mapped register");
  rdata_hi_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PRDATA_O[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  // read data is the register as seen at setup
  rd_edge_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && !PENABLE_I && hit_edge) |=> PRDATA_O[15:0] == $past(edge_ctl))
    else $error("edge control read wrong");
  rd_cur_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (PSEL_I && !PENABLE_I && hit_cur) |=> PRDATA_O[15:0] == $past(cur_ctl))
    else $error("current control read wrong");
  // mask register takes the written bits
  mask_wr_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr && hit_mask) |=> irq_mask == $past(PWDATA_I[1:0]))
    else $error("mask write lost");

  // software zero clears a seen bit when no edge competes
  clear_one_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr && hit_edge && !wd[etc_pkg::POS_SEEN1] && !hit1)
    |=> !edge_ctl[etc_pkg::POS_SEEN1])
    else $error("edge one seen bit not cleared");
  clear_two_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr && hit_edge && !wd[etc_pkg::POS_SEEN2] && !hit2)
    |=> !edge_ctl[etc_pkg::POS_SEEN2])
    else $error("edge two seen bit not cleared");
  // each edge also latches its interrupt status bit
  stat_one_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hit1 |=> irq_stat[0])
    else $error("edge one status not set");
  stat_two_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hit2 |=> irq_stat[1])
    else $error("edge two status not set");
  // write one clears a status bit unless an edge competes
  stat_w1c_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr && hit_stat && wd[0] && !hit1) |=> !irq_stat[0])
    else $error("status bit not cleared");

  // a select or polarity change never counts as an edge
  edge1_cfg_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hit1 |-> $stable(edge_ctl[etc_pkg::POS_SRC1 +: 3]))
    else $error("edge one hit on a setting change");
  edge2_cfg_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hit2 |-> $stable(edge_ctl[etc_pkg::POS_SRC2 +: 3]))
    else $error("edge two hit on a setting change");
  // analog and enable outputs follow their fields
  range_out_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr && hit_cur) |=> CURRENT_RANGE_O == $past(PWDATA_I[9:8]))
    else $error("range output wrong");
  trim_copy_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CURRENT_TRIM_O == cur_ctl[etc_pkg::POS_TRIM +: 6])
    else $error("trim output differs from register");
  range_copy_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CURRENT_RANGE_O == cur_ctl[etc_pkg::POS_RANGE +: 2])
    else $error("range output differs from register");
  gen_out_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    DELAY_GEN_ENABLE_O == edge_ctl[etc_pkg::POS_DELAY_GEN])
    else $error("delay generation output wrong");
  edge_rsvd_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (edge_ctl & ~(etc_pkg::EDGE_WMASK | 16'h0003)) == 16'h0000)
    else $error("edge control reserved bit set");
endmodule

/* File: logic/etc_pkg.sv */
// package for the edge-timed current control block
package etc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_EDGE_CTL = 8'h00;
  localparam logic [7:0] ADDR_CUR_CTL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // edge control field positions
  localparam int POS_DELAY_GEN = 12;
  localparam int POS_POL2 = 7;
  localparam int POS_SRC2 = 5;
  localparam int POS_POL1 = 4;
  localparam int POS_SRC1 = 2;
  localparam int POS_SEEN2 = 1;
  localparam int POS_SEEN1 = 0;
  // current control field positions
  localparam int POS_TRIM = 10;
  localparam int POS_RANGE = 8;
  // writable masks and reset values
  localparam logic [15:0] EDGE_WMASK = 16'h10FC;
  localparam logic [15:0] CUR_WMASK = 16'hFF00;
  localparam logic [15:0] EDGE_RESET = 16'h0000;
  localparam logic [15:0] CUR_RESET = 16'h0000;
  // edge source encodings
  localparam logic [1:0] SRC_PIN_ONE = 2'h3;
  localparam logic [1:0] SRC_PIN_TWO = 2'h2;
  localparam logic [1:0] SRC_COMPARE = 2'h1;
  localparam logic [1:0] SRC_TIMER = 2'h0;
  // edge source bundle
  typedef struct packed {
    logic pin_one;
    logic pin_two;
    logic compare;
    logic timer;
  } etc_src_t;
endpackage

/* File: logic/etc_edge_det.sv */
// one edge channel: source select, polarity, edge detect
`timescale 1ns/1ps
module etc_edge_det (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire etc_pkg::etc_src_t src_i,
  input wire logic [1:0] sel_i,
  input wire logic falling_i,
  // result
  output logic hit_o
);
  logic prev;
  logic [1:0] prev_sel;
  logic prev_falling;
  wire logic cur_lvl;
  wire logic qual_lvl;
  wire logic cfg_same;
  // source selection by code
  assign cur_lvl = (sel_i == etc_pkg::SRC_PIN_ONE) ? src_i.pin_one :
                   (sel_i == etc_pkg::SRC_PIN_TWO) ? src_i.pin_two :
                   (sel_i == etc_pkg::SRC_COMPARE) ? src_i.compare :
                   src_i.timer;
  // polarity invert so a rising qual_lvl is always the event
  assign qual_lvl = cur_lvl ^ falling_i;
  // a select or polarity change is not an edge; a real edge in that
  // same cycle is lost, so software sets the channel up first
  assign cfg_same = (sel_i == prev_sel) & (falling_i == prev_falling);
  // previous level and channel setting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev <= 1'b0;
      prev_sel <= 2'h0;
      prev_falling <= 1'b0;
    end else begin
      prev <= qual_lvl;
      prev_sel <= sel_i;
      prev_falling <= falling_i;
    end
  end
  assign hit_o = qual_lvl & ~prev & cfg_same;
endmodule

/* File: dv/etc_src_model.sv */
// edge source model: two pins, compare channel, timer
`timescale 1ns/1ps
module etc_src_model (
  // clock
  input wire logic clk_i,
  // source levels, all synchronous
  output etc_pkg::etc_src_t src_o
);
  // sources idle low
  initial src_o = '0;
  // bit index equals the source select code
  task automatic set_src(input logic [1:0] code, input logic lvl);
    @(posedge clk_i);
    src_o[code] <= lvl;
  endtask
endmodule

/* File: dv/etc_top_tb_top.sv */
// self-checking bench for the edge and current control block
`timescale 1ns/1ps
module etc_top_tb_top;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] pa = '0;
  logic [31:0] pwd = '0, prd, q;
  logic prdy, perr, dge, irq, e1;
  logic [5:0] trim;
  logic [1:0] rng;
  etc_pkg::etc_src_t src;
  int errors = 0, tests_run = 0;
  int ex;
  always #4 clk = ~clk;
  etc_src_model etc_src_model_i (.clk_i(clk), .src_o(src));
  etc_top etc_top_i (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .EDGE_PIN_ONE_I(src.pin_one), .EDGE_PIN_TWO_I(src.pin_two),
    .OUTPUT_COMPARE_ONE_I(src.compare), .GENERAL_TIMER_I(src.timer),
    .CURRENT_TRIM_O(trim), .CURRENT_RANGE_O(rng),
    .DELAY_GEN_ENABLE_O(dge), .IRQ_O(irq));
  // compare one result
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    q = prd;
    e1 = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, '0);
    cmp(q, x);
  endtask
  // raise then drop one source
  task automatic pulse(input logic [1:0] c);
    etc_src_model_i.set_src(c, 1);
    etc_src_model_i.set_src(c, 0);
  endtask
  task automatic t_current;
    chk(8'h04, 0);
    cmp(e1, 0);
    apb(1, 8'h04, 32'hFFFFFFFF);
    chk(8'h04, 32'h0000FF00);
    apb(1, 8'h04, 32'h0000A600);
    chk(8'h04, 32'h0000A600);
    cmp({trim, rng}, 8'hA6);
  endtask
  // reset in mid-run returns the fields and outputs to zero
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    cmp({trim, rng, dge, irq}, 0);
    chk(8'h04, 0);
    chk(8'h00, 0);
  endtask
  // every source code on edge 1, wrong source first
  task automatic t_sources;
    for (int c = 0; c < 4; c++) begin
      ex = c << 2;
      apb(1, 8'h00, ex);
      pulse(2'(c + 1));
      if (((c + 1) & 3) == 0) ex |= 2;
      chk(8'h00, ex);
      pulse(2'(c));
      ex |= (c == 0) ? 3 : 1;
      chk(8'h00, ex);
    end
  endtask
  // edge 2 falling; source, polarity and delay generation are set in one write
  task automatic t_edge2;
    apb(1, 8'h00, 32'h10E0);
    chk(8'h00, 32'h10E0);
    cmp(dge, 1);
    etc_src_model_i.set_src(2'h3, 1);
    chk(8'h00, 32'h10E0);
    etc_src_model_i.set_src(2'h3, 0);
    chk(8'h00, 32'h10E2);
    apb(1, 8'h00, 32'h0080);
    pulse(2'h0);
    chk(8'h00, 32'h0083);
    cmp(dge, 0);
    apb(1, 8'h00, 32'h10E0);
  endtask
  // status, mask, level interrupt and an unmapped address
  task automatic t_irq;
    apb(1, 8'h08, 3);
    apb(1, 8'h0C, 2);
    chk(8'h08, 0);
    cmp(irq, 0);
    pulse(2'h0);
    chk(8'h08, 1);
    cmp(irq, 0);
    pulse(2'h3);
    chk(8'h08, 3);
    cmp(irq, 1);
    apb(1, 8'h08, 2);
    chk(8'h08, 1);
    cmp(irq, 0);
    chk(8'h10, 0);
    cmp(e1, 1);
  endtask
  task automatic stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    chk(8'h00, 0);
    t_current;
    t_reset;
    t_sources;
    t_edge2;
    t_irq;
    stop_test;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test;
  end
endmodule
